// File: pkg/stpf_pkg.sv
// constants for the port-state and vlan forwarding gate
// assumes a 12-port switch core with an apb register slave
// ****************************************************************************
// Behaviour
// - bridge frame when destination is 01-80-c2-00-00-0x, any last nibble
// - redirect enabled bridge frames to cpu whatever the port state
// - redirected frame goes to queue chosen per address
// - redirected bridge frames end in the switch core; bridge frames not redirected forward like other frames
// - ingress source masks at entries 80-91, egress aggregation masks 64-79
// - discarding neither forwards nor learns; learning learns; forwarding does both
// - disabled, blocking, listening act exactly as discarding
// - learn only while the port learning enable is set
// - vlan table command 2 writes the entry at the selected index
// - with tagged frames dropped, frames classify to the port default vid
// - egress tag config zero sends frames untagged
// - vlan membership is independent of the port default vid
// - 4096 vlan entries reached through index and command registers
// - private vlan adds isolated mask for community, both masks for isolated
// ****************************************************************************
`default_nettype none
package stpf_pkg;
  localparam int NPORT = 12;
  localparam int NVLAN = 4096;
  localparam int NAGGR = 16;
  localparam int NADDR = 16;
  localparam logic [43:0] BPDU_PREFIX = 44'h0180c20000_0;
  // port group table entries
  localparam int PG_AGGR_BASE = 64;
  localparam int PG_SRC_BASE  = 80;
  localparam int PG_ENTRIES   = 92;
  // apb byte addresses
  localparam logic [11:0] A_VLAN_INDEX   = 12'h000;
  localparam logic [11:0] A_VLAN_CMD     = 12'h004;
  localparam logic [11:0] A_ISOL_MASK    = 12'h008;
  localparam logic [11:0] A_COMM_MASK    = 12'h00c;
  localparam logic [11:0] A_QUEUE_CFG    = 12'h010;
  localparam logic [11:0] A_STATUS       = 12'h014;
  localparam logic [11:0] A_PORT_BASE    = 12'h100;
  localparam logic [11:0] A_REDIR_BASE   = 12'h200;
  localparam logic [11:0] A_PGMASK_BASE  = 12'h400;
  // index register fields
  localparam int IDX_VID_LSB   = 0;
  localparam int IDX_PRIV_BIT  = 12;
  localparam int IDX_FLAGA_BIT = 13;
  localparam int IDX_NOLRN_BIT = 14;
  localparam int IDX_SRCCHK_BIT= 15;
  // command register fields
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_MASK_LSB  = 2;
  localparam logic [1:0] OP_IDLE  = 2'h0;
  localparam logic [1:0] OP_READ  = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  // port config register fields
  localparam int PC_VID_LSB    = 0;
  localparam int PC_DEI_BIT    = 12;
  localparam int PC_AWARE_BIT  = 13;
  localparam int PC_DRP_C_BIT  = 14;
  localparam int PC_DRP_PC_BIT = 15;
  localparam int PC_DRP_U_BIT  = 16;
  localparam int PC_LEARN_BIT  = 17;
  localparam int PC_TAG_LSB    = 18;
  localparam logic [1:0] TAG_NONE = 2'h0;
  localparam logic [31:0] PORT_CFG_RST = 32'h0000_0001;
  localparam logic [2:0]  QSEL_RST = 3'h0;
  // vlan entry: mask, srcchk, nolearn, flag_a, private
  localparam int VE_W = NPORT + 4;
  localparam logic [11:0] RST_VLAN_COUNT = 12'hfff;
endpackage
`default_nettype wire

// File: hdl/stpf_vlan_table.sv
// vlan table memory, one entry per vid
// assumes a synchronous single-port write and one async read per port
`timescale 1ns/100ps
`default_nettype none
module stpf_vlan_table
  import stpf_pkg::*;
#(
  parameter int DEPTH = NVLAN,
  parameter int W     = VE_W
)(
  input  wire logic          mclk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [11:0]   waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [11:0]   raddr_a,
  output logic      [W-1:0]  rdata_a,
  input  wire logic [11:0]   raddr_b,
  output logic      [W-1:0]  rdata_b
);
  logic [W-1:0] mem [DEPTH];
  always_ff @(posedge mclk)
  begin
    if (ce && we)
    begin
      mem[waddr] <= wdata;
    end
  end
  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule
`default_nettype wire

// File: hdl/stpf_gate.sv
// forwarding and learning gate with apb register slave
// assumes one frame descriptor per valid cycle, inputs synchronous to mclk
`timescale 1ns/100ps
`default_nettype none
module stpf_gate
  import stpf_pkg::*;
#(
  parameter int N = NPORT
)(
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          ce,
  // apb
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic      [31:0]   prdata,
  output logic               pslverr,
  // frame descriptor in
  input  wire logic          frm_valid,
  input  wire logic [3:0]    frm_src_port,
  input  wire logic [47:0]   frm_dmac,
  input  wire logic          frm_tagged,
  input  wire logic          frm_prio_tagged,
  input  wire logic [11:0]   frm_tag_vid,
  input  wire logic [3:0]    frm_aggr_sel,
  // decision out
  output logic               dec_valid,
  output logic               dec_drop,
  output logic [N-1:0]       dec_dest,
  output logic [11:0]        dec_vid,
  output logic               dec_learn,
  output logic               dec_to_cpu,
  output logic [2:0]         dec_cpu_queue,
  output logic [N-1:0]       dec_untag_mask
);
  typedef struct packed {
    logic [11:0]   vidx;
    logic          priv;
    logic          flag_a;
    logic          nolrn;
    logic          srcchk;
    logic [N-1:0]  vmask;
    logic [N-1:0]  isol;
    logic [N-1:0]  comm;
    logic [NADDR*3-1:0] qsel;
    logic [NPORT*32-1:0] pcfg;
    logic [N*NADDR-1:0] redir;
    logic [PG_ENTRIES*N-1:0] pg;
    logic          tbl_we;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    logic [31:0]   frames;
    logic          dv;
    logic          ddrop;
    logic [N-1:0]  ddest;
    logic [11:0]   dvid;
    logic          dlearn;
    logic          dcpu;
    logic [2:0]    dq;
    logic [N-1:0]  duntag;
  } stpf_state_s;

  stpf_state_s s_q;
  stpf_state_s s_d;
  logic [VE_W-1:0] wentry;
  logic [VE_W-1:0] rd_cls;
  logic [VE_W-1:0] rd_sw;
  logic [11:0]     cls_vid;
  logic [N-1:0]    untag_w;
  logic [N-1:0]    learn_w;
  logic [N-1:0]    aware_w;
  logic [N-1:0]    drop_c_w;
  logic [N-1:0]    drop_p_w;
  logic [N-1:0]    drop_u_w;
  logic [11:0]     pvid_w [N];
  logic            src_ok;
  logic [N-1:0]    srcmask_w;
  logic [N-1:0]    aggmask_w;

  // ****************************************************************
  // table and per-port egress tag decode
  // ****************************************************************
  assign wentry = {s_q.vmask, s_q.srcchk, s_q.nolrn, s_q.flag_a, s_q.priv};

  stpf_vlan_table #(.DEPTH(NVLAN), .W(VE_W)) u_tbl (
    .mclk    (mclk),
    .ce      (ce),
    .we      (s_q.tbl_we),
    .waddr   (s_q.vidx),
    .wdata   (wentry),
    .raddr_a (cls_vid),
    .rdata_a (rd_cls),
    .raddr_b (s_q.vidx),
    .rdata_b (rd_sw)
  );

  // per-port config field decode
  genvar gp;
  generate
    for (gp = 0; gp < N; gp++)
    begin : g_tag
      assign untag_w[gp]  = (s_q.pcfg[gp*32+PC_TAG_LSB +: 2] == TAG_NONE);
      assign learn_w[gp]  = s_q.pcfg[gp*32+PC_LEARN_BIT];
      assign aware_w[gp]  = s_q.pcfg[gp*32+PC_AWARE_BIT];
      assign drop_c_w[gp] = s_q.pcfg[gp*32+PC_DRP_C_BIT];
      assign drop_p_w[gp] = s_q.pcfg[gp*32+PC_DRP_PC_BIT];
      assign drop_u_w[gp] = s_q.pcfg[gp*32+PC_DRP_U_BIT];
      assign pvid_w[gp]   = s_q.pcfg[gp*32+PC_VID_LSB +: 12];
    end
  endgenerate

  // ****************************************************************
  // source port gating and classification vid
  // ****************************************************************
  // out-of-range source ports never index past the per-port tables
  assign src_ok    = (frm_src_port < 4'(N));
  assign srcmask_w = src_ok ? s_q.pg[(PG_SRC_BASE + 32'(frm_src_port))*N +: N] : '0;
  assign aggmask_w = s_q.pg[(PG_AGGR_BASE + 32'(frm_aggr_sel))*N +: N];

  // port default vid when tag unaware or tag dropped
  always_comb
  begin
    cls_vid = 12'h000;
    if (src_ok)
    begin
      if (aware_w[frm_src_port] && frm_tagged && !frm_prio_tagged && !drop_c_w[frm_src_port])
        cls_vid = frm_tag_vid;
      else
        cls_vid = pvid_w[frm_src_port];
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic [11:0]  off;
    logic         in_port;
    logic         in_redir;
    logic         in_pg;
    logic         is_bpdu;
    logic [3:0]   an;
    logic         drp;
    logic [N-1:0] m;
    logic [N-1:0] srcbit;
    logic         vm;
    logic         vpriv;
    logic         vnolrn;
    logic         vsrc;
    logic [N-1:0] vmsk;
    off    = '0;
    in_port  = 1'b0;
    in_redir = 1'b0;
    in_pg    = 1'b0;
    is_bpdu= 1'b0;
    an     = '0;
    drp    = 1'b0;
    m      = '0;
    srcbit = '0;
    vm     = 1'b0;
    vpriv  = 1'b0;
    vnolrn = 1'b0;
    vsrc   = 1'b0;
    vmsk   = '0;
    s_d        = s_q;
    s_d.tbl_we = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr= 1'b0;
    s_d.dv     = 1'b0;

    // ****************************************************************
    // apb slave, one wait state
    // ****************************************************************
    if (psel && penable && !s_q.pready)
    begin
      s_d.pready = 1'b1;
      s_d.prdata = '0;
      off = paddr;
      in_port  = (off >= A_PORT_BASE) && (off < A_PORT_BASE + 12'(N*4));
      in_redir = (off >= A_REDIR_BASE) && (off < A_REDIR_BASE + 12'(N*4));
      in_pg    = (off >= A_PGMASK_BASE) && (off < A_PGMASK_BASE + 12'(PG_ENTRIES*4));
      if (off == A_VLAN_INDEX)
      begin
        if (pwrite)
        begin
          s_d.vidx   = pwdata[IDX_VID_LSB +: 12];
          s_d.priv   = pwdata[IDX_PRIV_BIT];
          s_d.flag_a = pwdata[IDX_FLAGA_BIT];
          s_d.nolrn  = pwdata[IDX_NOLRN_BIT];
          s_d.srcchk = pwdata[IDX_SRCCHK_BIT];
        end
        s_d.prdata = {16'h0000, s_q.srcchk, s_q.nolrn, s_q.flag_a, s_q.priv, s_q.vidx};
      end
      else if (off == A_VLAN_CMD)
      begin
        if (pwrite)
        begin
          s_d.vmask = pwdata[CMD_MASK_LSB +: N];
          if (pwdata[CMD_OP_LSB +: 2] == OP_WRITE)
            s_d.tbl_we = 1'b1;
          else if (pwdata[CMD_OP_LSB +: 2] == OP_READ)
          begin
            s_d.vmask  = rd_sw[VE_W-1 -: N];
            s_d.srcchk = rd_sw[3];
            s_d.nolrn  = rd_sw[2];
            s_d.flag_a = rd_sw[1];
            s_d.priv   = rd_sw[0];
          end
        end
        s_d.prdata = 32'(s_q.vmask) << CMD_MASK_LSB;
      end
      else if (off == A_ISOL_MASK)
      begin
        if (pwrite) s_d.isol = pwdata[N-1:0];
        s_d.prdata = 32'(s_q.isol);
      end
      else if (off == A_COMM_MASK)
      begin
        if (pwrite) s_d.comm = pwdata[N-1:0];
        s_d.prdata = 32'(s_q.comm);
      end
      else if (off == A_QUEUE_CFG)
      begin
        if (pwrite) s_d.qsel[0 +: 32] = pwdata;
        s_d.prdata = s_q.qsel[0 +: 32];
      end
      else if (off == A_QUEUE_CFG + 12'h020)
      begin
        if (pwrite) s_d.qsel[32 +: 16] = pwdata[15:0];
        s_d.prdata = {16'h0000, s_q.qsel[32 +: 16]};
      end
      else if (off == A_STATUS)
        s_d.prdata = s_q.frames;
      else if (in_port)
      begin
        an = off[5:2];
        if (pwrite) s_d.pcfg[an*32 +: 32] = pwdata;
        s_d.prdata = s_q.pcfg[an*32 +: 32];
      end
      else if (in_redir)
      begin
        an = off[5:2];
        if (pwrite) s_d.redir[an*NADDR +: NADDR] = pwdata[NADDR-1:0];
        s_d.prdata = 32'(s_q.redir[an*NADDR +: NADDR]);
      end
      else if (in_pg)
      begin
        off = (off - A_PGMASK_BASE) >> 2;
        if (pwrite) s_d.pg[off*N +: N] = pwdata[N-1:0];
        s_d.prdata = 32'(s_q.pg[off*N +: N]);
      end
      else
        s_d.pslverr = 1'b1;
    end

    // ****************************************************************
    // frame decision
    // ****************************************************************
    if (frm_valid)
    begin
      is_bpdu = (frm_dmac[47:4] == BPDU_PREFIX);
      drp = !src_ok
         || (frm_tagged && !frm_prio_tagged && drop_c_w[frm_src_port])
         || (frm_prio_tagged && drop_p_w[frm_src_port])
         || (!frm_tagged && !frm_prio_tagged && drop_u_w[frm_src_port]);
      vmsk   = rd_cls[VE_W-1 -: N];
      vsrc   = rd_cls[3];
      vnolrn = rd_cls[2];
      vpriv  = rd_cls[0];
      srcbit = N'(1) << frm_src_port;
      vm     = |(vmsk & srcbit);
      m = vmsk;
      // a cleared bit marks the port class; the masks then gate by plain and
      if (vpriv && !(|(s_q.isol & srcbit)))
        m = m & s_q.isol & s_q.comm;
      else if (vpriv && !(|(s_q.comm & srcbit)))
        m = m & s_q.isol;
      // source mask and aggregation mask gate forwarding per port state
      m = m & srcmask_w & aggmask_w & ~srcbit;
      if (vsrc && !vm)
        m = '0;
      s_d.dv     = 1'b1;
      s_d.frames = s_q.frames + 32'h0000_0001;
      s_d.dvid   = cls_vid;
      s_d.duntag = untag_w;
      if (is_bpdu && src_ok && s_q.redir[frm_src_port*NADDR + frm_dmac[3:0]])
      begin
        s_d.ddrop  = 1'b0;
        s_d.ddest  = '0;
        s_d.dcpu   = 1'b1;
        s_d.dq     = s_q.qsel[frm_dmac[3:0]*3 +: 3];
        s_d.dlearn = 1'b0;
      end
      else
      begin
        s_d.ddrop  = drp || (m == '0);
        s_d.ddest  = drp ? '0 : m;
        s_d.dcpu   = 1'b0;
        s_d.dq     = '0;
        s_d.dlearn = !drp && learn_w[frm_src_port] && !vnolrn && !(vsrc && !vm);
      end
    end
  end

  // ****************************************************************
  // state register, frozen while ce is low
  // ****************************************************************
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_q <= '0;
      for (int i = 0; i < NPORT; i++)
        s_q.pcfg[i*32 +: 32] <= PORT_CFG_RST;
    end
    else if (ce)
      s_q <= s_d;
  end

  // ****************************************************************
  // outputs straight from the state register
  // ****************************************************************
  assign pready        = s_q.pready;
  assign prdata        = s_q.prdata;
  assign pslverr       = s_q.pslverr;
  assign dec_valid     = s_q.dv;
  assign dec_drop      = s_q.ddrop;
  assign dec_dest      = s_q.ddest;
  assign dec_vid       = s_q.dvid;
  assign dec_learn     = s_q.dlearn;
  assign dec_to_cpu    = s_q.dcpu;
  assign dec_cpu_queue = s_q.dq;
  assign dec_untag_mask= s_q.duntag;
endmodule
`default_nettype wire

// File: sim/stpf_gate_assertions.sv
// port checker for the forwarding gate
// assumes binding onto stpf_gate, one clock domain
`timescale 1ns/100ps
`default_nettype none
module stpf_gate_assertions
  import stpf_pkg::*;
#(
  parameter int N = NPORT
)(
  input wire logic         mclk,
  input wire logic         reset,
  input wire logic         ce,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pready,
  input wire logic [31:0]  prdata,
  input wire logic         pslverr,
  input wire logic         frm_valid,
  input wire logic [3:0]   frm_src_port,
  input wire logic [47:0]  frm_dmac,
  input wire logic         dec_valid,
  input wire logic         dec_drop,
  input wire logic [N-1:0] dec_dest,
  input wire logic         dec_learn,
  input wire logic         dec_to_cpu
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  a_apb_one_wait: assert property (psel && penable && !pready && ce |=> pready)
    else $error("apb answer late");
  a_apb_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("apb answer without access");
  a_ready_one_cycle: assert property (pready && ce |=> !pready)
    else $error("apb answer too long");
  a_unmapped_clean: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("apb error carries data");
  a_dec_follows: assert property (frm_valid && ce |=> dec_valid)
    else $error("decision missing");
  a_dec_has_cause: assert property (dec_valid |-> $past(frm_valid && ce))
    else $error("decision without frame");
  a_cpu_frame_clean: assert property (dec_valid && dec_to_cpu |-> dec_dest == '0 && !dec_learn && !dec_drop)
    else $error("redirected frame forwarded");
  a_bridge_addr: assert property (dec_valid && dec_to_cpu |-> $past(frm_dmac[47:4]) == BPDU_PREFIX)
    else $error("redirect of other address");
  a_no_self_dest: assert property (dec_valid |-> ((dec_dest >> $past(frm_src_port)) & 1) == 0)
    else $error("frame sent back to source");
  a_dec_holds: assert property (!dec_valid |-> $stable(dec_dest) && $stable(dec_learn))
    else $error("decision changed without frame");
endmodule
bind stpf_gate stpf_gate_assertions #(.N(N)) u_chk (.mclk, .reset, .ce, .psel, .penable, .pready, .prdata,
  .pslverr, .frm_valid, .frm_src_port, .frm_dmac, .dec_valid, .dec_drop, .dec_dest, .dec_learn, .dec_to_cpu);
`default_nettype wire

// File: sim/stpf_lan_peer.sv
// neighbour bridges on the lan ports, one descriptor per call
// assumes the bench calls send from its main process
`timescale 1ns/100ps
`default_nettype none
module stpf_lan_peer (
  input  wire logic  mclk,
  output logic        frm_valid,
  output logic [3:0]  frm_src_port,
  output logic [47:0] frm_dmac,
  output logic        frm_tagged,
  output logic        frm_prio_tagged,
  output logic [11:0] frm_tag_vid,
  output logic [3:0]  frm_aggr_sel
);
  initial
  begin
    {frm_valid, frm_src_port, frm_dmac, frm_tagged, frm_prio_tagged, frm_tag_vid, frm_aggr_sel} = '0;
  end
  // ****************************************
  // frames only on request, scrambled when idle
  // ****************************************
  task automatic send(input logic [3:0] p, input logic [47:0] da, input logic [1:0] tg, input logic [3:0] ag);
    @(posedge mclk);
    frm_valid <= 1'b1;
    frm_src_port <= p;
    frm_dmac <= da;
    frm_tagged <= (tg == 2'h1);
    frm_prio_tagged <= (tg == 2'h2);
    frm_tag_vid <= da[15:4];
    frm_aggr_sel <= ag;
    @(posedge mclk);
    frm_valid <= 1'b0;
    frm_src_port <= ~p;
    frm_dmac <= ~da;
    frm_tagged <= ~frm_tagged;
    frm_tag_vid <= ~da[15:4];
    frm_aggr_sel <= ~ag;
  endtask
endmodule
`default_nettype wire

// File: sim/stpf_gate_tb.sv
// self-checking bench for the forwarding gate
// assumes stpf_pkg, the gate, its checker and the lan peer model
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, gt); end end
module stpf_gate_tb;
  import stpf_pkg::*;
  logic        mclk, reset, ce, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr, vm[4], agm[16], fw;
  logic [31:0] pwdata, prdata, q, sd;
  logic        frm_valid, frm_tagged, frm_prio_tagged, dec_valid, dec_drop, dec_learn, dec_to_cpu, nl[4];
  logic [3:0]  frm_src_port, frm_aggr_sel;
  logic [47:0] frm_dmac, qs, da;
  logic [11:0] frm_tag_vid, dec_dest, dec_vid, dec_untag_mask;
  logic [2:0]  dec_cpu_queue;
  logic        pr[4], sc[4];
  logic [11:0] im, cm, ut, ed;
  int          err_count, n_checks, st[12], pv[12], p, n, tg, ag, bp, red;
  stpf_gate dut (.mclk, .reset, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .frm_valid, .frm_src_port, .frm_dmac, .frm_tagged, .frm_prio_tagged, .frm_tag_vid, .frm_aggr_sel,
    .dec_valid, .dec_drop, .dec_dest, .dec_vid, .dec_learn, .dec_to_cpu, .dec_cpu_queue, .dec_untag_mask);
  stpf_lan_peer peer (.mclk, .frm_valid, .frm_src_port, .frm_dmac, .frm_tagged, .frm_prio_tagged,
    .frm_tag_vid, .frm_aggr_sel);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs();
    sd ^= sd << 13;
    sd ^= sd >> 17;
    sd ^= sd << 5;
    return sd;
  endfunction
  function automatic logic [11:0] ad(input logic [11:0] b, input int i);
    return b + 12'(4 * i);
  endfunction
  function automatic logic [11:0] exp_dest(input int sp, input int sg);
    logic [11:0] m;
    int          v;
    v = pv[sp];
    m = vm[v] & agm[sg] & (fw[sp] ? ~(12'h1 << sp) : 12'h0);
    if (pr[v] && !im[sp])
      m = m & im & cm;
    else if (pr[v] && !cm[sp])
      m = m & im;
    if (sc[v] && !vm[v][sp])
      m = 12'h0;
    return m;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    #200000;
    err_count++;
    final_report;
  end
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    {reset, ce, psel, penable, pwrite, paddr, pwdata, sd} = {1'b1, 1'b1, 47'h0, 32'hfa56};
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    for (p = 0; p < 12; p++)
    begin
      apb(1'b0, ad(A_PORT_BASE, p), 32'h0);
      `CHK("port_cfg_reset", 32'h1, q)
    end
    apb(1'b1, 12'hffc, 32'h5);
    `CHK("unmapped_err", 1'b1, e)
    $display("test registers done");
    for (int r = 0; r < 2; r++)
    begin
      for (int v = 1; v < 4; v++)
      begin
        vm[v] = 12'(xs());
        nl[v] = 1'(xs());
        pr[v] = 1'(xs());
        sc[v] = (xs() % 4 == 0);
        apb(1'b1, A_VLAN_INDEX, {16'h0, sc[v], nl[v], 1'b0, pr[v], 12'(v)});
        apb(1'b1, A_VLAN_CMD, {18'h0, vm[v], OP_WRITE});
      end
      im = 12'(xs());
      cm = 12'(xs());
      apb(1'b1, A_ISOL_MASK, {20'h0, im});
      apb(1'b1, A_COMM_MASK, {20'h0, cm});
      fw = '0;
      for (p = 0; p < 12; p++)
      begin
        st[p] = xs() % 3;
        pv[p] = 1 + xs() % 3;
        ut[p] = 1'(xs());
        if (st[p] == 2) fw[p] = 1'b1;
        apb(1'b1, ad(A_REDIR_BASE, p), r ? 32'hffff : 32'h1);
        apb(1'b1, ad(A_PORT_BASE, p), 32'(pv[p]) | 32'hc000 | (st[p] != 0 ? 32'h20000 : 32'h0)
          | (ut[p] ? 32'h0 : 32'h40000));
        apb(1'b1, ad(A_PGMASK_BASE, PG_SRC_BASE + p), st[p] == 2 ? {20'h0, 12'hfff & ~(12'h1 << p)} : 32'h0);
      end
      for (int g = 0; g < 16; g++)
      begin
        agm[g] = fw & 12'(xs());
        apb(1'b1, ad(A_PGMASK_BASE, PG_AGGR_BASE + g), {20'h0, agm[g]});
      end
      qs = 48'({xs(), xs()});
      apb(1'b1, A_QUEUE_CFG, qs[31:0]);
      apb(1'b1, 12'h030, {16'h0, qs[47:32]});
      for (int f = 0; f < 60; f++)
      begin
        p = xs() % 12;
        n = xs() % 16;
        bp = xs() % 2;
        tg = xs() % 4;
        ag = xs() % 16;
        da = bp ? {BPDU_PREFIX, 4'(n)} : 48'({xs(), xs()});
        red = bp && (r == 1 || n == 0);
        peer.send(4'(p), da, 2'(tg), 4'(ag));
        #1;
        ed = exp_dest(p, ag);
        `CHK("dec_valid", 1'b1, dec_valid)
        `CHK("to_cpu", 1'(red), dec_to_cpu)
        if (red)
        begin
          `CHK("cpu_queue", qs[3*n+:3], dec_cpu_queue)
          `CHK("cpu_dest", 12'h0, dec_dest)
        end
        else
        begin
          `CHK("drop", 1'(tg == 1 || tg == 2 || ed == 12'h0), dec_drop)
          if (tg == 0 || tg == 3)
          begin
            `CHK("vid", 12'(pv[p]), dec_vid)
            `CHK("dest", ed, dec_dest)
            `CHK("learn", 1'(st[p] != 0 && !nl[pv[p]] && !(sc[pv[p]] && !vm[pv[p]][p])), dec_learn)
            `CHK("untag", ut, dec_untag_mask)
          end
        end
      end
      apb(1'b0, A_STATUS, 32'h0);
      `CHK("frame_count", 32'(60 * (r + 1)), q)
      $display("test round %0d done", r);
    end
    final_report;
  end
endmodule
`default_nettype wire
